// ===== core/isd_pkg.sv
// Constants and types for the initial speed detect configuration bank
//
// Behaviour
// [RULE_01] Speed detection before driving runs only when bit 30 is one.
// [RULE_02] Braking within speed detection is allowed only when bit 29 is one.
// [RULE_03] Floating the outputs during detection is allowed only when bit 28 is one.
// [RULE_04] Reverse drive of a backward-spinning motor is allowed only when bit 27 is one.
// [RULE_05] Resynchronising to a forward-spinning motor is allowed only when bit 26 is one.
// [RULE_06] Bits 25-22 pick the resync minimum speed, 5% to 100% of maximum.
// [RULE_07] Bit 21 one brakes with all low-side switches; zero is reserved.
// [RULE_08] Bit 20 zero exits braking on time; one uses current and time.
// [RULE_09] Bits 19-17 pick braking current 0.0625 A to 2.5 A; code 7 reserved.
// [RULE_10] Bits 16-13 pick braking duration, 10 ms up to 15 s.
// [RULE_11] Software leaves unlisted offsets in the area untouched.
// [RULE_12] The detection word at offset 80h resets to all zeros.
// [RULE_13] Bits 8-6 pick the standstill back-EMF level, 50 to 1500 mV.
// [RULE_14] Bits 5-2 pick the reverse-to-open-loop handoff speed.
// [RULE_15] Bits 1-0 pick the reversal open-loop current limit, 0.9375 A to 3.125 A.
// [RULE_16] The top bit reads zero and ignores writes.
package sdc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] SDC_OFS_DETECT = 12'h0080;
	localparam int SDC_NUM_OTHER = 13;
	localparam logic [SDC_NUM_OTHER-1:0][11:0] SDC_OFS_OTHER = {
		12'h009e, 12'h009c, 12'h009a, 12'h0098, 12'h0096, 12'h0094,
		12'h008e, 12'h008c, 12'h008a, 12'h0088, 12'h0086, 12'h0084, 12'h0082};
	localparam logic [31:0] SDC_DETECT_RESET = 32'h0000_0000;
	localparam logic [31:0] SDC_OTHER_RESET = 32'h0000_0000;
	localparam logic [31:0] SDC_DETECT_WMASK = 32'h7fff_ffff;

	// ----------------------------------------
	// Field positions of the detection word
	// ----------------------------------------
	localparam int SDC_B_DETECT = 30;
	localparam int SDC_B_BRAKE = 29;
	localparam int SDC_B_FLOAT = 28;
	localparam int SDC_B_REVERSE = 27;
	localparam int SDC_B_RESYNC = 26;
	localparam int SDC_F_RESYNC_HI = 25;
	localparam int SDC_F_RESYNC_LO = 22;
	localparam int SDC_B_STYLE = 21;
	localparam int SDC_B_EXIT = 20;
	localparam int SDC_F_CURR_HI = 19;
	localparam int SDC_F_CURR_LO = 17;
	localparam int SDC_F_DUR_HI = 16;
	localparam int SDC_F_DUR_LO = 13;
	localparam int SDC_F_FLOATT_HI = 12;
	localparam int SDC_F_FLOATT_LO = 9;
	localparam int SDC_F_BEMF_HI = 8;
	localparam int SDC_F_BEMF_LO = 6;
	localparam int SDC_F_HAND_HI = 5;
	localparam int SDC_F_HAND_LO = 2;
	localparam int SDC_F_REVI_HI = 1;
	localparam int SDC_F_REVI_LO = 0;

	// ----------------------------------------
	// Codes and tables
	// ----------------------------------------
	localparam logic SDC_STYLE_LOW_SIDE = 1'b1;
	localparam logic SDC_EXIT_TIME_ONLY = 1'b0;
	localparam logic [2:0] SDC_CURR_RESERVED = 3'h7;
	// Braking current levels in 1/16 A steps
	localparam logic [7:0][7:0] SDC_CURR_TABLE = {
		8'hff, 8'h28, 8'h14, 8'h0a, 8'h05, 8'h03, 8'h02, 8'h01};
	// Braking durations in ms, code 0 in the lowest slot
	localparam logic [15:0][13:0] SDC_DUR_MS_TABLE = {
		14'h3a98, 14'h2710, 14'h1d4c, 14'h1388, 14'h0fa0, 14'h0bb8, 14'h07d0, 14'h03e8,
		14'h02ee, 14'h01f4, 14'h0190, 14'h012c, 14'h00c8, 14'h0064, 14'h0032, 14'h000a};

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SDC_CLK_PERIOD_NS = 50;
	localparam int SDC_MS_NS = 1000000;
	localparam int SDC_MS_CYCLES = SDC_MS_NS / SDC_CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		SDC_ST_IDLE = 2'b00,
		SDC_ST_BRAKE = 2'b01
	} sdc_brake_e;

endpackage

// ===== core/initial_speed_detect_cfg_bank.sv
// Detection configuration bank with braking exit timer
`timescale 1ns/1ps
module sdc_config_bank
#(
	parameter int MS_CYCLES = sdc_pkg::SDC_MS_CYCLES
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register access
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// Configuration fields
	output logic speed_detect_allow,
	output logic braking_allow,
	output logic detect_float_allow,
	output logic reverse_drive_allow,
	output logic forward_resync_allow,
	output logic [3:0] resync_speed_level,
	output logic braking_style,
	output logic braking_exit_rule,
	output logic [2:0] braking_current_level,
	output logic [3:0] braking_duration,
	output logic [3:0] float_duration,
	output logic [2:0] standstill_bemf_level,
	output logic [3:0] reverse_handoff_speed,
	output logic [1:0] reverse_openloop_current_limit,
	// Braking sequence
	input wire logic brake_start,
	input wire logic [7:0] brake_current,
	output logic low_side_all_on,
	output logic brake_done,
	output logic brake_refused
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		logic [31:0] detect;
		logic [sdc_pkg::SDC_NUM_OTHER-1:0][31:0] other;
		logic [31:0] rdata;
		logic rvalid;
		sdc_pkg::sdc_brake_e st;
		logic [31:0] tick;
		logic [13:0] ms;
		logic [13:0] ms_limit;
		logic [7:0] curr_limit;
		logic use_curr;
		logic low_on;
		logic done;
		logic refused;
	} sdc_state_s;

	sdc_state_s s_reg;
	sdc_state_s s_next;

	// ----------------------------------------
	// Address decoding
	// ----------------------------------------
	// True when the offset selects the detection word
	function automatic logic sdc_is_detect(input logic [11:0] addr);
		return addr == sdc_pkg::SDC_OFS_DETECT;
	endfunction

	// Index of a listed non-detection offset; hit low when none matches
	function automatic logic [4:0] sdc_other_index(input logic [11:0] addr, output logic hit);
		logic [4:0] idx;
		idx = 5'h00;
		hit = 1'b0;
		for (int i = 0; i < sdc_pkg::SDC_NUM_OTHER; i++)
		begin
			if (addr == sdc_pkg::SDC_OFS_OTHER[i])
			begin
				idx = 5'(i);
				hit = 1'b1;
			end
		end
		return idx;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic hit;
		logic [4:0] idx;
		logic allowed;
		logic [13:0] dur_ms;
		logic [2:0] curr_code;
		hit = 1'b0;
		idx = 5'h00;
		allowed = 1'b0;
		dur_ms = 14'h0000;
		curr_code = 3'h0;
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.refused = 1'b0;
		s_next.rvalid = reg_rd;
		idx = sdc_other_index(reg_addr, hit);

		// Writes; unlisted offsets are left alone [RULE_11]
		if (reg_wr)
		begin
			if (sdc_is_detect(reg_addr))
			begin
				s_next.detect = reg_wdata & sdc_pkg::SDC_DETECT_WMASK; // [RULE_16]
			end
			else if (hit)
			begin
				s_next.other[idx] = reg_wdata;
			end
		end

		// Reads answer one cycle later; unlisted offsets read zero
		if (reg_rd)
		begin
			if (sdc_is_detect(reg_addr))
			begin
				s_next.rdata = s_reg.detect;
			end
			else if (hit)
			begin
				s_next.rdata = s_reg.other[idx];
			end
			else
			begin
				s_next.rdata = 32'h0000_0000;
			end
		end

		// Braking runs only inside enabled detection with a valid style [RULE_01] [RULE_02] [RULE_07]
		allowed = s_reg.detect[sdc_pkg::SDC_B_DETECT] & s_reg.detect[sdc_pkg::SDC_B_BRAKE]
			& (s_reg.detect[sdc_pkg::SDC_B_STYLE] == sdc_pkg::SDC_STYLE_LOW_SIDE);
		dur_ms = sdc_pkg::SDC_DUR_MS_TABLE[s_reg.detect[sdc_pkg::SDC_F_DUR_HI:sdc_pkg::SDC_F_DUR_LO]]; // [RULE_10]
		curr_code = s_reg.detect[sdc_pkg::SDC_F_CURR_HI:sdc_pkg::SDC_F_CURR_LO];

		unique case (s_reg.st)
			sdc_pkg::SDC_ST_IDLE:
			begin
				if (brake_start)
				begin
					if (allowed)
					begin
						s_next.st = sdc_pkg::SDC_ST_BRAKE;
						s_next.low_on = 1'b1; // [RULE_07]
						s_next.tick = 32'h0000_0000;
						s_next.ms = 14'h0000;
						s_next.ms_limit = dur_ms; // [RULE_10]
						s_next.curr_limit = sdc_pkg::SDC_CURR_TABLE[curr_code]; // [RULE_09]
						// Reserved current code falls back to time-only exit [RULE_09]
						s_next.use_curr = (s_reg.detect[sdc_pkg::SDC_B_EXIT] != sdc_pkg::SDC_EXIT_TIME_ONLY)
							&& (curr_code != sdc_pkg::SDC_CURR_RESERVED); // [RULE_08]
					end
					else
					begin
						s_next.refused = 1'b1; // [RULE_02]
					end
				end
			end
			sdc_pkg::SDC_ST_BRAKE:
			begin
				if (s_reg.tick == 32'(MS_CYCLES - 1))
				begin
					s_next.tick = 32'h0000_0000;
					s_next.ms = s_reg.ms + 14'h0001;
				end
				else
				begin
					s_next.tick = s_reg.tick + 32'h0000_0001;
				end
				// Time always ends braking; current may end it earlier [RULE_08]
				if ((s_reg.ms >= s_reg.ms_limit) || (s_reg.use_curr && (brake_current < s_reg.curr_limit)))
				begin
					s_next.st = sdc_pkg::SDC_ST_IDLE;
					s_next.low_on = 1'b0;
					s_next.done = 1'b1;
				end
			end
			default:
			begin
				s_next.st = sdc_pkg::SDC_ST_IDLE;
				s_next.low_on = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_reg <= '0;
			s_reg.detect <= sdc_pkg::SDC_DETECT_RESET; // [RULE_12]
			s_reg.other <= {sdc_pkg::SDC_NUM_OTHER{sdc_pkg::SDC_OTHER_RESET}};
			s_reg.st <= sdc_pkg::SDC_ST_IDLE;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = s_reg.rdata;
	assign reg_rvalid = s_reg.rvalid;
	assign speed_detect_allow = s_reg.detect[sdc_pkg::SDC_B_DETECT]; // [RULE_01]
	assign braking_allow = s_reg.detect[sdc_pkg::SDC_B_BRAKE]; // [RULE_02]
	assign detect_float_allow = s_reg.detect[sdc_pkg::SDC_B_FLOAT]; // [RULE_03]
	assign reverse_drive_allow = s_reg.detect[sdc_pkg::SDC_B_REVERSE]; // [RULE_04]
	assign forward_resync_allow = s_reg.detect[sdc_pkg::SDC_B_RESYNC]; // [RULE_05]
	assign resync_speed_level = s_reg.detect[sdc_pkg::SDC_F_RESYNC_HI:sdc_pkg::SDC_F_RESYNC_LO]; // [RULE_06]
	assign braking_style = s_reg.detect[sdc_pkg::SDC_B_STYLE]; // [RULE_07]
	assign braking_exit_rule = s_reg.detect[sdc_pkg::SDC_B_EXIT]; // [RULE_08]
	assign braking_current_level = s_reg.detect[sdc_pkg::SDC_F_CURR_HI:sdc_pkg::SDC_F_CURR_LO]; // [RULE_09]
	assign braking_duration = s_reg.detect[sdc_pkg::SDC_F_DUR_HI:sdc_pkg::SDC_F_DUR_LO]; // [RULE_10]
	assign float_duration = s_reg.detect[sdc_pkg::SDC_F_FLOATT_HI:sdc_pkg::SDC_F_FLOATT_LO];
	assign standstill_bemf_level = s_reg.detect[sdc_pkg::SDC_F_BEMF_HI:sdc_pkg::SDC_F_BEMF_LO]; // [RULE_13]
	assign reverse_handoff_speed = s_reg.detect[sdc_pkg::SDC_F_HAND_HI:sdc_pkg::SDC_F_HAND_LO]; // [RULE_14]
	assign reverse_openloop_current_limit = s_reg.detect[sdc_pkg::SDC_F_REVI_HI:sdc_pkg::SDC_F_REVI_LO]; // [RULE_15]
	assign low_side_all_on = s_reg.low_on;
	assign brake_done = s_reg.done;
	assign brake_refused = s_reg.refused;

endmodule

// ===== verification/initial_speed_detect_cfg_bank_asserts.sv
// Port checks for the detection configuration bank
`timescale 1ns/1ps
module sdc_config_bank_asserts
#(
	parameter int MS_CYCLES = sdc_pkg::SDC_MS_CYCLES
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// Configuration fields
	input wire logic speed_detect_allow,
	input wire logic braking_allow,
	input wire logic detect_float_allow,
	input wire logic reverse_drive_allow,
	input wire logic forward_resync_allow,
	input wire logic braking_style,
	input wire logic braking_exit_rule,
	input wire logic [3:0] resync_speed_level,
	input wire logic [3:0] braking_duration,
	input wire logic [3:0] float_duration,
	input wire logic [3:0] reverse_handoff_speed,
	input wire logic [2:0] braking_current_level,
	input wire logic [2:0] standstill_bemf_level,
	input wire logic [1:0] reverse_openloop_current_limit,
	// Braking sequence
	input wire logic brake_start,
	input wire logic low_side_all_on,
	input wire logic brake_done,
	input wire logic brake_refused,
	input wire logic [7:0] brake_current
);
	localparam logic [7:0][7:0] THR = {8'hff, 8'h28, 8'h14, 8'h0a, 8'h05, 8'h03, 8'h02, 8'h01};
	logic [31:0] fld;
	logic [31:0] lim;
	logic [31:0] run_reg;
	logic [31:0] run_next;
	logic idle;
	logic ok;
	assign fld = {1'b0, speed_detect_allow, braking_allow, detect_float_allow, reverse_drive_allow,
		forward_resync_allow, resync_speed_level, braking_style, braking_exit_rule, braking_current_level,
		braking_duration, float_duration, standstill_bemf_level, reverse_handoff_speed,
		reverse_openloop_current_limit};
	assign idle = !low_side_all_on && !brake_done;
	assign ok = speed_detect_allow && braking_allow && braking_style;
	assign lim = sdc_pkg::SDC_DUR_MS_TABLE[braking_duration] * MS_CYCLES;
	// Length of the current braking run
	assign run_next = low_side_all_on ? run_reg + 32'h0000_0001 : 32'h0000_0000;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			run_reg <= 32'h0000_0000;
		else
			run_reg <= run_next;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_reset_zero; !$past(rst_n) |-> fld == 32'h0000_0000 && !low_side_all_on; endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("fields not clear after reset");
	property p_write; reg_wr && reg_addr == 12'h0080 |=> fld == ($past(reg_wdata) & 32'h7fff_ffff); endproperty
	a_write: assert property (p_write) else $error("fields differ from written word");
	property p_read; reg_rd && !reg_wr && reg_addr == 12'h0080 |=> reg_rvalid && reg_rdata == fld; endproperty
	a_read: assert property (p_read) else $error("read word differs from fields");
	property p_off; idle && !speed_detect_allow |=> !low_side_all_on; endproperty
	a_off: assert property (p_off) else $error("braking with detection off");
	property p_refuse; brake_start && idle && !ok |=> brake_refused && !low_side_all_on; endproperty
	a_refuse: assert property (p_refuse) else $error("start not refused");
	property p_enter; brake_start && idle && ok |=> low_side_all_on && !brake_refused; endproperty
	a_enter: assert property (p_enter) else $error("braking not entered");
	property p_cur_exit;
		low_side_all_on && braking_exit_rule && braking_current_level != 3'h7
			&& brake_current < THR[braking_current_level] |-> ##[1:2] !low_side_all_on;
	endproperty
	a_cur_exit: assert property (p_cur_exit) else $error("no exit below current level");
	property p_time;
		$fell(low_side_all_on) |-> brake_done && run_reg <= lim + 2 && (braking_exit_rule || run_reg >= lim);
	endproperty
	a_time: assert property (p_time) else $error("braking length wrong");
	c_refused: cover property (brake_refused);
	c_cur_exit: cover property ($fell(low_side_all_on) && braking_exit_rule);
	c_read: cover property (reg_rvalid);
endmodule
bind sdc_config_bank sdc_config_bank_asserts #(.MS_CYCLES(MS_CYCLES)) i_chk (.*);

// ===== verification/tb_initial_speed_detect_cfg_bank.sv
// Self-checking bench for the detection configuration bank
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb_initial_speed_detect_config;
	localparam int MS = 1;
	localparam int DUR[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000, 5000, 7500, 10000, 15000};
	localparam int THR[7] = '{1, 2, 3, 5, 10, 20, 40};
	localparam logic [11:0] BAD[3] = '{12'h0081, 12'h0090, 12'h00a0};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic brake_start = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [7:0] brake_current = 8'h00;
	logic [31:0] reg_rdata;
	logic reg_rvalid, low_side_all_on, brake_done, brake_refused;
	wire [30:0] fld;
	logic [31:0] d, e80, ex;
	logic [11:0] a;
	logic [31:0] exp_q[$];
	int ev_q[$];
	int n_mismatch = 0;
	int comparisons = 0;
	int i, c, hi;
	int run = 0;
	sdc_config_bank #(.MS_CYCLES(MS)) i_dut (.*, .speed_detect_allow(fld[30]), .braking_allow(fld[29]),
		.detect_float_allow(fld[28]), .reverse_drive_allow(fld[27]), .forward_resync_allow(fld[26]),
		.resync_speed_level(fld[25:22]), .braking_style(fld[21]), .braking_exit_rule(fld[20]),
		.braking_current_level(fld[19:17]), .braking_duration(fld[16:13]), .float_duration(fld[12:9]),
		.standstill_bemf_level(fld[8:6]), .reverse_handoff_speed(fld[5:2]), .reverse_openloop_current_limit(fld[1:0]));
	always #25 ref_clk = ~ref_clk;
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] v);
		reg_addr = ad;
		reg_wdata = v;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		step();
	endtask
	task automatic rd(input logic [11:0] ad, input logic [31:0] ex);
		exp_q.push_back(ex);
		reg_addr = ad;
		reg_rd = 1'b1;
		step();
		reg_rd = 1'b0;
		step();
	endtask
	// Note 0 for a refusal, else the longest allowed run
	task automatic brake(input logic [31:0] cfg, input logic [7:0] cur, input int h);
		wr(12'h0080, cfg);
		ev_q.push_back(h);
		brake_current = cur;
		brake_start = 1'b1;
		step();
		brake_start = 1'b0;
		c = 0;
		while (!(brake_done || brake_refused) && c < 20000)
		begin
			step();
			c++;
		end
		if (c == 20000)
		begin
			n_mismatch++;
			close_out();
		end
		step();
	endtask
	always @(posedge ref_clk)
	begin
		if (low_side_all_on)
			run++;
		if (reg_rvalid)
		begin
			// An answer with no note left must not pass
			ex = exp_q.size() > 0 ? exp_q.pop_front() : ~reg_rdata;
			`CHK(reg_rdata, ex)
		end
		if (brake_refused || brake_done)
			hi = ev_q.size() > 0 ? ev_q.pop_front() : -1;
		if (brake_refused)
			`CHK(0, hi)
		if (brake_done)
		begin
			`CHK(run <= hi && run + 2 >= hi, 1'b1)
			run = 0;
		end
	end
	initial
	begin
		void'($urandom(32'hacd55a78));
		repeat (16) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		step();
		rd(12'h0080, 32'h0000_0000);
		for (i = 0; i < 8; i++)
		begin
			d = $urandom();
			// Keep the reserved braking style and current codes out
			d[21] = 1'b1;
			if (d[19:17] == 3'h7)
				d[17] = 1'b0;
			wr(12'h0080, d);
			`CHK(fld, d[30:0])
			rd(12'h0080, d & 32'h7fff_ffff);
		end
		e80 = d & 32'h7fff_ffff;
		for (i = 0; i < 13; i++)
		begin
			a = 12'h0082 + 12'(2 * i) + (i > 6 ? 12'h0004 : 12'h0000);
			d = $urandom();
			wr(a, d);
			rd(a, d);
		end
		// Unlisted offsets are only read, never written
		foreach (BAD[k])
			rd(BAD[k], 32'h0000_0000);
		rd(12'h0080, e80);
		$display("test register access done");
		for (i = 0; i < 8; i++)
			brake({1'b0, i[2], i[1], 7'h00, 1'b1, i[0], 20'h0_0000}, 8'hff, i >= 6 ? DUR[0] * MS + 2 : 0);
		$display("test braking refusal done");
		for (i = 0; i < 16; i++)
			brake(32'h6020_0000 | (i << 13), 8'h00, DUR[i] * MS + 2);
		$display("test braking duration done");
		for (i = 0; i < 7; i++)
		begin
			d = 32'h6030_4000 | (i << 17);
			brake(d, 8'($urandom_range(0, THR[i] - 1)), 3);
			brake(d, 8'(THR[i] + $urandom_range(0, 9)), DUR[2] * MS + 2);
		end
		$display("test braking current exit done");
		`CHK(exp_q.size() + ev_q.size(), 0)
		close_out();
	end
endmodule
